// ---- rtl/pie_pkg.sv ----
// package: register map, field positions and bus codes of the enable bank
package pie_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // byte addresses of the registers
  localparam logic [ADDR_W-1:0] CORE_CTRL_OFS = 8'h88;
  localparam logic [ADDR_W-1:0] ENABLE_1_OFS = 8'h8c;
  localparam logic [ADDR_W-1:0] FLAG_1_OFS = 8'h90;
  // reset values
  localparam logic [REG_W-1:0] ENABLE_1_RST = 8'h00;
  localparam logic [REG_W-1:0] CORE_CTRL_RST = 8'h00;
  localparam logic [REG_W-1:0] FLAG_1_RST = 8'h00;
  // core control field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int GROUP_EN_BIT = 6;
  localparam logic [REG_W-1:0] CORE_CTRL_MASK = 8'hc0;
  // enable bank field positions, one source each
  localparam int EEPROM_WR_BIT = 7;
  localparam int CONV_DONE_BIT = 6;
  localparam int SER_RX_BIT = 5;
  localparam int SER_TX_BIT = 4;
  localparam int SYNC_SER_BIT = 3;
  localparam int CAPCOMP1_BIT = 2;
  localparam int TIMER2_MATCH_BIT = 1;
  localparam int TIMER1_OVF_BIT = 0;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ---- rtl/pie_enable_bank.sv ----
// peripheral interrupt enable bank with an axi4-lite register slave
// Functional notes
// - no peripheral interrupt without group enable bit
// - 8-bit rw enable register, clears at reset
// - bit 5 gates serial receive interrupt
// - bit 4 gates serial transmit interrupt
// - bit 3 gates sync serial port interrupt
// - bit 2 gates capture/compare 1 interrupt
// - bit 1 gates timer two match interrupt
// - flags set regardless of any enable
`timescale 1ns/1ps
module pie_enable_bank (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // one-cycle event pulses from the peripherals, same clock
  input wire logic [pie_pkg::REG_W-1:0] i_event,
  // axi4-lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [pie_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // axi4-lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [pie_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [pie_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // axi4-lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [pie_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  // gated per-source requests and the combined interrupt
  output logic [pie_pkg::REG_W-1:0] o_src_req,
  output logic o_irq
);
  import pie_pkg::*;

  logic [REG_W-1:0] enable_1;
  logic [REG_W-1:0] core_ctrl;
  logic [REG_W-1:0] flag_1;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic aw_hs;
  logic w_hs;
  logic do_write;
  logic ar_hs;
  logic flag_rd_clr;
  logic [REG_W-1:0] next_flag;
  logic [REG_W-1:0] gated;

  // true for any address that holds a register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == CORE_CTRL_OFS) || (a == ENABLE_1_OFS) ||
           (a == FLAG_1_OFS);
  endfunction

  // register contents as seen by a read, upper bits zero
  function automatic logic [DATA_W-1:0] rd_word(
    input logic [ADDR_W-1:0] a,
    input logic [REG_W-1:0] ctl,
    input logic [REG_W-1:0] en,
    input logic [REG_W-1:0] fl);
    logic [REG_W-1:0] v;
    v = '0;
    case (a)
      CORE_CTRL_OFS: v = ctl & CORE_CTRL_MASK;
      ENABLE_1_OFS: v = en;
      FLAG_1_OFS: v = fl;
      default: v = '0;
    endcase
    return {{(DATA_W-REG_W){1'b0}}, v};
  endfunction

  // handshake terms
  assign aw_hs = i_awvalid && o_awready;
  assign w_hs = i_wvalid && o_wready;
  assign ar_hs = i_arvalid && o_arready;
  // both halves held and no response outstanding
  assign do_write = !o_awready && !o_wready && !o_bvalid;
  assign flag_rd_clr = ar_hs && (i_araddr == FLAG_1_OFS);

  // write address channel: one write in flight at a time
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready <= 1'b1;
      aw_addr <= '0;
    end else if (aw_hs) begin
      o_awready <= 1'b0;
      aw_addr <= i_awaddr;
    end else if (o_bvalid && i_bready) begin
      o_awready <= 1'b1;
    end
  end

  // write data channel, taken in either order against the address
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wready <= 1'b1;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_hs) begin
      o_wready <= 1'b0;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end else if (o_bvalid && i_bready) begin
      o_wready <= 1'b1;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (o_bvalid && i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // enable bank: plain read/write byte, lane 0 only
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      enable_1 <= ENABLE_1_RST;
    end else if (do_write && aw_addr == ENABLE_1_OFS && w_strb[0]) begin
      enable_1 <= w_data[REG_W-1:0];
    end
  end

  // core control: global and group enables, other bits reserved
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      core_ctrl <= CORE_CTRL_RST;
    end else if (do_write && aw_addr == CORE_CTRL_OFS && w_strb[0]) begin
      core_ctrl <= w_data[REG_W-1:0] & CORE_CTRL_MASK;
    end
  end

  // flags latch every event whatever the enables; a new event
  // beats the read that clears, so nothing is lost
  always_comb begin
    next_flag = flag_1;
    if (flag_rd_clr) begin
      next_flag = '0;
    end
    next_flag = next_flag | i_event;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_1 <= FLAG_1_RST;
    end else begin
      flag_1 <= next_flag;
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= RDATA_ZERO;
      o_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_word(i_araddr, core_ctrl, enable_1, flag_1);
      o_rresp <= is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
    end
  end

  // each flag reaches the request only through its own enable
  // and the group enable; software should clear stale flags
  // before enabling, or an old event fires at once
  assign gated = flag_1 & enable_1 &
                 {REG_W{core_ctrl[GROUP_EN_BIT]}};

  // registered outputs: one cycle from flag to request
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_src_req <= '0;
    end else begin
      o_src_req <= gated;
    end
  end

  // level interrupt also needs the global enable
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= core_ctrl[GLOBAL_EN_BIT] && (|gated);
    end
  end

  // group enable off means no request and no interrupt
  a_group_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !core_ctrl[GROUP_EN_BIT] |=> (o_src_req == '0) && !o_irq)
    else $error("request passed with group enable off");

  // a write of lane 0 to the enable bank lands next cycle
  a_enable_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    do_write && aw_addr == ENABLE_1_OFS && w_strb[0]
    |=> enable_1 == $past(w_data[REG_W-1:0]) && o_bvalid &&
        o_bresp == RESP_OKAY)
    else $error("enable bank write not stored");

  a_rx_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    ##1 o_src_req[SER_RX_BIT] == $past(flag_1[SER_RX_BIT] &&
      enable_1[SER_RX_BIT] && core_ctrl[GROUP_EN_BIT]))
    else $error("serial receive gate wrong");

  a_tx_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !enable_1[SER_TX_BIT] |=> !o_src_req[SER_TX_BIT])
    else $error("serial transmit passed while disabled");

  a_sync_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    flag_1[SYNC_SER_BIT] && enable_1[SYNC_SER_BIT] &&
    core_ctrl[GROUP_EN_BIT] |=> o_src_req[SYNC_SER_BIT])
    else $error("sync serial request missing");

  a_capcomp_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    ##1 o_src_req[CAPCOMP1_BIT] == $past(flag_1[CAPCOMP1_BIT] &&
      enable_1[CAPCOMP1_BIT] && core_ctrl[GROUP_EN_BIT]))
    else $error("capture compare gate wrong");

  a_timer2_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !enable_1[TIMER2_MATCH_BIT] |=> !o_src_req[TIMER2_MATCH_BIT])
    else $error("timer two match passed while disabled");

  a_irq_combine: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    ##1 o_irq == $past(core_ctrl[GLOBAL_EN_BIT] && (|(flag_1 &
      enable_1 & {REG_W{core_ctrl[GROUP_EN_BIT]}}))))
    else $error("interrupt output does not match gated flags");

  a_flag_sets: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    i_event[SER_RX_BIT] |=> flag_1[SER_RX_BIT])
    else $error("event lost from flag register");

  // a disabled sync serial source never requests
  a_sync_block: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !enable_1[SYNC_SER_BIT] |=> !o_src_req[SYNC_SER_BIT])
    else $error("sync serial passed while disabled");

  // timer two match passes once flag, enable and group agree
  a_timer2_pass: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    flag_1[TIMER2_MATCH_BIT] && enable_1[TIMER2_MATCH_BIT] &&
    core_ctrl[GROUP_EN_BIT] |=> o_src_req[TIMER2_MATCH_BIT])
    else $error("timer two match request missing");

  // the three further sources follow their own enable bits
  a_eeprom_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    ##1 o_src_req[EEPROM_WR_BIT] == $past(flag_1[EEPROM_WR_BIT] &&
      enable_1[EEPROM_WR_BIT] && core_ctrl[GROUP_EN_BIT]))
    else $error("eeprom write done gate wrong");

  a_conv_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    ##1 o_src_req[CONV_DONE_BIT] == $past(flag_1[CONV_DONE_BIT] &&
      enable_1[CONV_DONE_BIT] && core_ctrl[GROUP_EN_BIT]))
    else $error("conversion done gate wrong");

  a_timer1_gate: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    ##1 o_src_req[TIMER1_OVF_BIT] == $past(flag_1[TIMER1_OVF_BIT] &&
      enable_1[TIMER1_OVF_BIT] && core_ctrl[GROUP_EN_BIT]))
    else $error("timer one overflow gate wrong");

  // a read of the flags empties them unless a new event lands
  a_flag_clear: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    flag_rd_clr && (i_event == '0) |=> flag_1 == '0)
    else $error("flag register not cleared by read");

  // the enable bank holds unless a lane 0 write to it lands
  a_enable_hold: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    !(do_write && aw_addr == ENABLE_1_OFS && w_strb[0])
    |=> $stable(enable_1))
    else $error("enable bank changed without a write");

  // unmapped writes answer slave error and touch no register
  a_write_refused: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    do_write && !is_mapped(aw_addr)
    |=> o_bresp == RESP_SLVERR && $stable(enable_1) &&
        $stable(core_ctrl))
    else $error("unmapped write not refused");

  // a read of the enable bank returns the byte, upper bits zero
  a_enable_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_nrst)
    ar_hs && i_araddr == ENABLE_1_OFS
    |=> o_rvalid && o_rdata == {{(DATA_W-REG_W){1'b0}}, $past(enable_1)})
    else $error("enable bank read data wrong");

endmodule // pie_enable_bank

// ---- test/peripheral_irq_enable_bank_tb_top.sv ----
// self-checking bench for the peripheral interrupt enable bank
`timescale 1ns/1ps
module peripheral_irq_enable_bank_tb_top;
  import pie_pkg::*;
  logic i_sys_clk = 0, i_nrst = 0, i_awvalid = 0, i_wvalid = 0;
  logic i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [7:0] i_event = 0, i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0;
  logic [3:0] i_wstrb = 4'hf;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [7:0] o_src_req;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'h36b8;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  pie_enable_bank uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_event(i_event), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_awaddr(i_awaddr), .i_awprot(3'h0), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .i_arprot(3'h0), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_src_req(o_src_req), .o_irq(o_irq));
  always #4 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [33:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bus master write; both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    // one edge between calls, so no signal is set twice in a step
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    while (!(aw && w)) begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) begin aw = 1; i_awvalid <= 0; end
      if (i_wvalid && o_wready) begin w = 1; i_wvalid <= 0; end
    end
    do @(posedge i_sys_clk); while (o_bvalid !== 1'b1);
    i_bready <= 0;
    chk("bresp", {32'h0, er}, {32'h0, o_bresp});
  endtask
  // bus master read; the expectation goes to the queue for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    exp_q.push_back({er, d});
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    do @(posedge i_sys_clk); while (o_arready !== 1'b1);
    i_arvalid <= 0;
    do @(posedge i_sys_clk); while (o_rvalid !== 1'b1);
    i_rready <= 0;
  endtask
  // events are one cycle wide; outputs settle two edges later
  task automatic pulse(input logic [7:0] ev);
    @(posedge i_sys_clk) i_event <= ev;
    @(posedge i_sys_clk) i_event <= 8'h00;
    repeat (2) @(posedge i_sys_clk);
  endtask
  // read monitor takes the oldest note at each read handshake
  always @(posedge i_sys_clk) begin
    if (o_rvalid === 1'b1 && i_rready) begin
      if (exp_q.size() == 0) chk("unexpected read", 34'h0, 34'h3_ffff_ffff);
      else chk("read", exp_q.pop_front(), {o_rresp, o_rdata});
    end
  end
  // hang guard well above the few hundred cycles the sequence needs
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin : main
    logic [31:0] r;
    repeat (16) @(posedge i_sys_clk);
    i_nrst <= 1;
    rd(ENABLE_1_OFS, 32'h0, RESP_OKAY);
    rd(CORE_CTRL_OFS, 32'h0, RESP_OKAY);
    // random full words: only the low byte is kept, upper reads zero
    repeat (4) begin
      seed = xs(seed);
      r = seed;
      wr(ENABLE_1_OFS, r, RESP_OKAY);
      rd(ENABLE_1_OFS, {24'h0, r[7:0]}, RESP_OKAY);
    end
    // lane 0 strobe low: answered okay, enable bank keeps its byte
    i_wstrb <= 4'he;
    wr(ENABLE_1_OFS, ~r, RESP_OKAY);
    i_wstrb <= 4'hf;
    rd(ENABLE_1_OFS, {24'h0, r[7:0]}, RESP_OKAY);
    // unmapped place refuses with slave error and reads zero
    wr(8'h8d, 32'hff, RESP_SLVERR);
    rd(8'h8d, 32'h0, RESP_SLVERR);
    // one source enabled at a time, every event fired, global alternates
    for (int i = 0; i < 8; i++) begin
      rd(FLAG_1_OFS, 32'h0, RESP_OKAY);
      wr(ENABLE_1_OFS, 32'h1 << i, RESP_OKAY);
      wr(CORE_CTRL_OFS, (i % 2) ? 32'h40 : 32'hc0, RESP_OKAY);
      pulse(8'hff);
      chk("src_req", 34'h1 << i, {26'h0, o_src_req});
      chk("irq", (i % 2) ? 34'h0 : 34'h1, {33'h0, o_irq});
      rd(FLAG_1_OFS, 32'hff, RESP_OKAY);
      repeat (2) @(posedge i_sys_clk);
      chk("src_req after clear", 34'h0, {26'h0, o_src_req});
    end
    // group enable off blocks every source even with all enabled
    wr(CORE_CTRL_OFS, 32'h80, RESP_OKAY);
    wr(ENABLE_1_OFS, 32'hff, RESP_OKAY);
    pulse(8'hff);
    chk("src_req no group", 34'h0, {26'h0, o_src_req});
    chk("irq no group", 34'h0, {33'h0, o_irq});
    rd(CORE_CTRL_OFS, 32'h80, RESP_OKAY);
    rd(FLAG_1_OFS, 32'hff, RESP_OKAY);
    repeat (4) @(posedge i_sys_clk);
    chk("queue drained", 34'h0, exp_q.size());
    end_of_test();
  end
endmodule // peripheral_irq_enable_bank_tb_top
